// >>> src/ivp_pkg.sv
// Package: vector map constants for the vector placement block
package ivp_pkg;
   localparam int ADDR_W = 14;
   localparam int NUM_IRQ = 25;
   localparam int IDX_W = 5;
   localparam logic [ADDR_W-1:0] RESET_ADDR_APP = 14'h0000;
   localparam logic [ADDR_W-1:0] BOOT_RESET_16K = 14'h1c00;
   localparam logic [ADDR_W-1:0] BOOT_RESET_8K = 14'h0c00;
   localparam logic [ADDR_W-1:0] VEC_STRIDE_16K = 14'h0002;
   localparam logic [ADDR_W-1:0] VEC_STRIDE_8K = 14'h0001;
   localparam logic [ADDR_W-1:0] VEC_FIRST_16K = 14'h0002;
   localparam logic [ADDR_W-1:0] VEC_FIRST_8K = 14'h0001;
   localparam logic FUSE_UNPROGRAMMED = 1'b1;
   localparam logic [7:0] MCU_CTRL_ADDR = 8'h35;
   localparam int VSEL_BIT = 1;
   localparam int VCE_BIT = 0;
   localparam logic [7:0] MCU_CTRL_RESET = 8'h00;
   localparam logic [IDX_W-1:0] IDX_PROGRAM_STORE_READY = 5'h18;
   typedef enum logic [2:0] {
      IVP_RESET = 3'b001,
      IVP_IDLE = 3'b010,
      IVP_WAIT = 3'b100
   } ivp_state_e;
endpackage

// >>> src/ivp_if.sv
// Interface: pending request vector between arbiter and sequencer
`timescale 1ns/10ps
interface ivp_arb_if;
   logic [ivp_pkg::NUM_IRQ-1:0] pending;
   logic valid;
   logic [ivp_pkg::IDX_W-1:0] index;
   modport arb (input pending, output valid, output index);
   modport seq (output pending, input valid, input index);
endinterface

// >>> src/ivp_arbiter.sv
// Fixed-priority pick of the lowest numbered pending request
`timescale 1ns/10ps
module ivp_arbiter (
   ivp_arb_if.arb arb
);
   always_comb begin
      arb.valid = 1'b0;
      arb.index = '0;
      for (int i = ivp_pkg::NUM_IRQ - 1; i >= 0; i--) begin
         if (arb.pending[i]) begin
            arb.valid = 1'b1;
            arb.index = ivp_pkg::IDX_W'(i);
         end
      end
   end
endmodule

// >>> src/ivp_top.sv
// Top: reset and interrupt vector address generation
//
// What this block does
// - Unprogrammed fuse: reset starts at zero
// - Programmed fuse: reset at boot address
// - Fuse one unprogrammed, zero programmed
// - Select bit adds boot start to vectors
// - First vector 0x002 or boot plus 0x0002
// - External requests at 0x0002 and 0x0004
// - Pin change groups at 0x0006 to 0x000A
// - Async timer vectors 0x000E to 0x0012
// - Sixteen-bit timer vectors 0x0014 to 0x001A
// - First timer vectors 0x001C to 0x0020
// - Serial transfer complete at 0x0022
// - Serial port vectors 0x0024 to 0x0028
// - Program store ready last at 0x0032
// - Vectors two words apart, fixed order
// - Reset and vector base chosen independently
// - Small variant boot reset at 0xC00
// - Small variant one-word vectors, 0x001 upward
// - Select bit 1, change enable bit 0
`timescale 1ns/10ps
module ivp_top #(
   parameter bit WIDE_VECTORS = 1'b1
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Fuse strap, sampled after reset release
   input wire logic boot_reset_fuse_i,
   // Control register write port from the core
   input wire logic ctrl_we_i,
   input wire logic [7:0] ctrl_addr_i,
   input wire logic [7:0] ctrl_wdata_i,
   // Interrupt requests, bit 0 is vector number 2
   input wire logic [ivp_pkg::NUM_IRQ-1:0] irq_i,
   // Fetch side handshake with the core
   input wire logic ack_i,
   output logic fetch_valid_o,
   output logic fetch_is_reset_o,
   output logic [ivp_pkg::ADDR_W-1:0] fetch_addr_o,
   output logic [ivp_pkg::IDX_W-1:0] fetch_index_o,
   // Control register readback
   output logic [7:0] mcu_control_reg_o
);
   ivp_arb_if arb_bus ();

   ivp_arbiter u_arb (
      .arb(arb_bus.arb)
   );

   logic [ivp_pkg::NUM_IRQ-1:0] irq_m;
   logic [ivp_pkg::NUM_IRQ-1:0] irq_s;
   logic fuse_m;
   logic fuse_s;
   logic fuse_latched;
   logic vector_select_boot;
   logic vector_change_enable;
   logic next_fuse_latched;
   logic next_vector_select_boot;
   logic next_vector_change_enable;
   ivp_pkg::ivp_state_e state;
   ivp_pkg::ivp_state_e next_state;
   logic valid;
   logic next_valid;
   logic is_reset;
   logic next_is_reset;
   logic [ivp_pkg::ADDR_W-1:0] addr;
   logic [ivp_pkg::ADDR_W-1:0] next_addr;
   logic [ivp_pkg::IDX_W-1:0] index;
   logic [ivp_pkg::IDX_W-1:0] next_index;
   logic [ivp_pkg::ADDR_W-1:0] boot_base;
   logic [ivp_pkg::ADDR_W-1:0] stride;
   logic [ivp_pkg::ADDR_W-1:0] first_vec;
   logic [ivp_pkg::ADDR_W-1:0] vec_base;
   logic [ivp_pkg::ADDR_W-1:0] reset_target;
   logic [ivp_pkg::ADDR_W-1:0] vec_addr;
   logic offer_vec;

   // Pins are asynchronous: two stages before any use
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_m <= '0;
         irq_s <= '0;
      end else begin
         irq_m <= irq_i;
         irq_s <= irq_m;
      end
   end

   // Fuse stages run through reset, so the strap has settled at release
   always_ff @(posedge sys_clk_i) begin
      fuse_m <= boot_reset_fuse_i;
      fuse_s <= fuse_m;
   end

   assign arb_bus.pending = irq_s;
   assign offer_vec = state == ivp_pkg::IVP_IDLE && arb_bus.valid;

   // Vector map: width follows the variant
   always_comb begin
      if (WIDE_VECTORS) begin
         boot_base = ivp_pkg::BOOT_RESET_16K;
         stride = ivp_pkg::VEC_STRIDE_16K;
         first_vec = ivp_pkg::VEC_FIRST_16K;
      end else begin
         boot_base = ivp_pkg::BOOT_RESET_8K;
         stride = ivp_pkg::VEC_STRIDE_8K;
         first_vec = ivp_pkg::VEC_FIRST_8K;
      end
   end

   // Reset target and vector base are decided apart
   always_comb begin
      if (fuse_latched == ivp_pkg::FUSE_UNPROGRAMMED) begin
         reset_target = ivp_pkg::RESET_ADDR_APP;
      end else begin
         reset_target = boot_base;
      end
      if (vector_select_boot) begin
         vec_base = boot_base;
      end else begin
         vec_base = ivp_pkg::RESET_ADDR_APP;
      end
   end

   // Offset = first + index*stride covers every table entry in order
   assign vec_addr = ivp_pkg::ADDR_W'(vec_base + first_vec
      + ivp_pkg::ADDR_W'(arb_bus.index) * stride);

   // Control register: select bit changes only with change enable set
   always_comb begin
      next_vector_select_boot = vector_select_boot;
      next_vector_change_enable = 1'b0;
      if (ctrl_we_i && ctrl_addr_i == ivp_pkg::MCU_CTRL_ADDR) begin
         next_vector_change_enable = ctrl_wdata_i[ivp_pkg::VCE_BIT];
         if (vector_change_enable && !ctrl_wdata_i[ivp_pkg::VCE_BIT]) begin
            next_vector_select_boot = ctrl_wdata_i[ivp_pkg::VSEL_BIT];
         end
      end
   end

   // Fetch sequencer: reset fetch first, then one vector per ack
   always_comb begin
      next_state = state;
      next_valid = valid;
      next_is_reset = is_reset;
      next_addr = addr;
      next_index = index;
      next_fuse_latched = fuse_latched;
      case (state)
         ivp_pkg::IVP_RESET: begin
            // Fuse strap caught once synchronised
            next_fuse_latched = fuse_s;
            next_state = ivp_pkg::IVP_WAIT;
            next_valid = 1'b1;
            next_is_reset = 1'b1;
            next_addr = (fuse_s == ivp_pkg::FUSE_UNPROGRAMMED)
               ? ivp_pkg::RESET_ADDR_APP : boot_base;
            next_index = '0;
         end
         ivp_pkg::IVP_IDLE: begin
            if (arb_bus.valid) begin
               next_state = ivp_pkg::IVP_WAIT;
               next_valid = 1'b1;
               next_is_reset = 1'b0;
               next_addr = vec_addr;
               next_index = arb_bus.index;
            end
         end
         ivp_pkg::IVP_WAIT: begin
            if (ack_i) begin
               next_state = ivp_pkg::IVP_IDLE;
               next_valid = 1'b0;
               next_is_reset = 1'b0;
            end
         end
         default: begin
            next_state = ivp_pkg::IVP_RESET;
            next_valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= ivp_pkg::IVP_RESET;
         valid <= 1'b0;
         is_reset <= 1'b0;
         addr <= ivp_pkg::RESET_ADDR_APP;
         index <= '0;
         fuse_latched <= ivp_pkg::FUSE_UNPROGRAMMED;
         vector_select_boot <= ivp_pkg::MCU_CTRL_RESET[ivp_pkg::VSEL_BIT];
         vector_change_enable <= ivp_pkg::MCU_CTRL_RESET[ivp_pkg::VCE_BIT];
      end else begin
         state <= next_state;
         valid <= next_valid;
         is_reset <= next_is_reset;
         addr <= next_addr;
         index <= next_index;
         fuse_latched <= next_fuse_latched;
         vector_select_boot <= next_vector_select_boot;
         vector_change_enable <= next_vector_change_enable;
      end
   end

   assign fetch_valid_o = valid;
   assign fetch_is_reset_o = is_reset;
   assign fetch_addr_o = addr;
   assign fetch_index_o = index;
   always_comb begin
      mcu_control_reg_o = 8'h00;
      mcu_control_reg_o[ivp_pkg::VSEL_BIT] = vector_select_boot;
      mcu_control_reg_o[ivp_pkg::VCE_BIT] = vector_change_enable;
   end

   reset_app_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      valid && is_reset && fuse_latched |-> addr == ivp_pkg::RESET_ADDR_APP)
      else $error("reset fetch not at zero with fuse unprogrammed");
   reset_boot_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      valid && is_reset && !fuse_latched |-> addr == boot_base)
      else $error("reset fetch not at boot address");
   vec_boot_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state == ivp_pkg::IVP_IDLE && arb_bus.valid && vector_select_boot
      |=> addr >= boot_base + first_vec)
      else $error("relocated vector below boot section");
   vec_first_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state == ivp_pkg::IVP_IDLE && arb_bus.valid && arb_bus.index == 0
      && !vector_select_boot |=> addr == first_vec)
      else $error("first vector misplaced");
   vec_last_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state == ivp_pkg::IVP_IDLE && arb_bus.valid && WIDE_VECTORS
      && arb_bus.index == ivp_pkg::IDX_PROGRAM_STORE_READY && !vector_select_boot
      |=> addr == 14'h0032)
      else $error("program store ready vector misplaced");
   vec_prio_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state == ivp_pkg::IVP_IDLE && irq_s[0] |=> valid && index == 0)
      else $error("lowest pending vector not taken");
   vsel_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !vector_change_enable |=> $stable(vector_select_boot))
      else $error("select bit changed without change enable");
   fetch_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      valid && !ack_i |=> valid && $stable(addr))
      else $error("fetch address dropped before ack");

   // Spot checks of map and sequencing; the fixed-address ones hold only in the variant they name
   reset_offer_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state == ivp_pkg::IVP_RESET |=> valid && is_reset && index == 0)
      else $error("reset fetch not offered first");
   fuse_keep_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state != ivp_pkg::IVP_RESET |=> $stable(fuse_latched))
      else $error("fuse value changed after reset fetch");
   fuse_take_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state == ivp_pkg::IVP_RESET |=> fuse_latched == $past(fuse_s))
      else $error("fuse value not caught at release");
   vec_app_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      offer_vec && !vector_select_boot |=> addr < boot_base)
      else $error("vector left application section");
   ext_one_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      offer_vec && arb_bus.index == 1 && !vector_select_boot
      |=> addr == first_vec + stride)
      else $error("second external request misplaced");
   pin_change_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      offer_vec && WIDE_VECTORS && arb_bus.index == 4 && !vector_select_boot
      |=> addr == 14'h000a)
      else $error("third pin change vector misplaced");
   wdog_vec_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      offer_vec && WIDE_VECTORS && arb_bus.index == 5 && !vector_select_boot
      |=> addr == 14'h000c)
      else $error("watchdog vector misplaced");
   timer_capt_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      offer_vec && WIDE_VECTORS && arb_bus.index == 9 && !vector_select_boot
      |=> addr == 14'h0014)
      else $error("capture vector misplaced");
   spi_done_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      offer_vec && WIDE_VECTORS && arb_bus.index == 16 && !vector_select_boot
      |=> addr == 14'h0022)
      else $error("transfer complete vector misplaced");
   narrow_last_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      offer_vec && !WIDE_VECTORS && arb_bus.index == ivp_pkg::IDX_PROGRAM_STORE_READY
      && vector_select_boot |=> addr == 14'h0c19)
      else $error("relocated one-word table end misplaced");
   narrow_boot_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      valid && is_reset && !fuse_latched && !WIDE_VECTORS |-> addr == 14'h0c00)
      else $error("small variant boot reset misplaced");
   idle_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state == ivp_pkg::IVP_IDLE && !arb_bus.valid |=> !valid)
      else $error("fetch offered with nothing pending");
   ack_drop_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      valid && ack_i |=> !valid)
      else $error("fetch still offered after ack");
   vce_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      vector_change_enable && !ctrl_we_i |=> !vector_change_enable)
      else $error("change enable stood past its window");
   vsel_take_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      vector_change_enable && ctrl_we_i
      && ctrl_addr_i == ivp_pkg::MCU_CTRL_ADDR
      && !ctrl_wdata_i[ivp_pkg::VCE_BIT]
      |=> vector_select_boot == $past(ctrl_wdata_i[ivp_pkg::VSEL_BIT]))
      else $error("enabled select write not taken");
   ctrl_spare_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      mcu_control_reg_o[7:2] == 6'h00)
      else $error("unused control bits not zero");
endmodule

// >>> tb/ivp_core_model.sv
// Core fetch side model: accepts each offered fetch after a set wait
`timescale 1ns/10ps
module ivp_core_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Offered fetch
   input wire logic fetch_valid_i,
   input wire logic [13:0] fetch_addr_i,
   input wire logic [4:0] fetch_index_i,
   input wire logic fetch_is_reset_i,
   input wire logic [3:0] lat_i,
   // Acceptance and record of the last taken fetch
   output logic ack_o,
   output int n_taken,
   output logic [13:0] taken_addr,
   output logic [4:0] taken_index,
   output logic taken_is_reset
);
   int wait_cnt;
   // Ack is a one-cycle pulse, so a level-only design cannot pass
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_o <= 1'b0;
         wait_cnt <= 0;
         n_taken <= 0;
      end else if (ack_o && fetch_valid_i) begin
         ack_o <= 1'b0;
         wait_cnt <= 0;
         n_taken <= n_taken + 1;
         taken_addr <= fetch_addr_i;
         taken_index <= fetch_index_i;
         taken_is_reset <= fetch_is_reset_i;
      end else if (fetch_valid_i && !ack_o) begin
         if (wait_cnt >= int'(lat_i)) ack_o <= 1'b1;
         else wait_cnt <= wait_cnt + 1;
      end
   end
endmodule

// >>> tb/ivp_top_tb.sv
// Self-checking bench for both vector map variants of the top
`timescale 1ns/10ps
module ivp_top_tb;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic fuse = 1'b1;
   logic we = 1'b0;
   logic [7:0] wa = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [24:0] irq = '0;
   logic [3:0] lat = 4'h3;
   logic ackw, ackn, vw, vn, rw, rn, tw_r, tn_r;
   logic [13:0] aw, an, tw_a, tn_a;
   logic [4:0] iw, in_, tw_i, tn_i;
   logic [7:0] ctrl;
   int tw, tn, cyc = 0;
   int n_mismatch = 0;
   int n_checks = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   ivp_top DUT (.sys_clk_i, .resetn_i, .boot_reset_fuse_i(fuse),
      .ctrl_we_i(we), .ctrl_addr_i(wa), .ctrl_wdata_i(wd), .irq_i(irq),
      .ack_i(ackw), .fetch_valid_o(vw), .fetch_is_reset_o(rw),
      .fetch_addr_o(aw), .fetch_index_o(iw), .mcu_control_reg_o(ctrl));
   ivp_top #(.WIDE_VECTORS(1'b0)) DUT_N (.sys_clk_i, .resetn_i,
      .boot_reset_fuse_i(fuse), .ctrl_we_i(we), .ctrl_addr_i(wa),
      .ctrl_wdata_i(wd), .irq_i(irq), .ack_i(ackn), .fetch_valid_o(vn),
      .fetch_is_reset_o(rn), .fetch_addr_o(an), .fetch_index_o(in_),
      .mcu_control_reg_o());
   ivp_core_model CW (.clk_i(sys_clk_i), .resetn_i, .fetch_valid_i(vw),
      .fetch_addr_i(aw), .fetch_index_i(iw), .fetch_is_reset_i(rw),
      .lat_i(lat), .ack_o(ackw), .n_taken(tw), .taken_addr(tw_a),
      .taken_index(tw_i), .taken_is_reset(tw_r));
   ivp_core_model CN (.clk_i(sys_clk_i), .resetn_i, .fetch_valid_i(vn),
      .fetch_addr_i(an), .fetch_index_i(in_), .fetch_is_reset_i(rn),
      .lat_i(lat), .ack_o(ackn), .n_taken(tn), .taken_addr(tn_a),
      .taken_index(tn_i), .taken_is_reset(tn_r));
   task automatic give_verdict();
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Whole run needs about 900 cycles
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic wait_takes(input int w0, input int n0);
      for (int i = 0; i < 60 && (tw == w0 || tn == n0); i++) tick(1);
   endtask
   task automatic do_reset(input logic f, input logic [3:0] l);
      tick(1);
      resetn_i = 1'b0;
      fuse = f;
      lat = l;
      tick(16);
      resetn_i = 1'b1;
      wait_takes(0, 0);
      check(16'({tw_r, tn_r}), 16'h3);
      check(16'(tw_a), f ? 16'h0 : 16'(ivp_pkg::BOOT_RESET_16K));
      check(16'(tn_a), f ? 16'h0 : 16'(ivp_pkg::BOOT_RESET_8K));
      check(16'(ctrl), 16'h0);
   endtask
   // Strobe stays up so back-to-back writes never toggle it in one step
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      we = 1'b1;
      wa = a;
      wd = d;
      tick(1);
   endtask
   // Enable then select on the very next cycle
   task automatic set_select(input logic s);
      write(8'h35, 8'h01);
      write(8'h35, {6'h0, s, 1'b0});
      we = 1'b0;
      check(16'(ctrl), {14'h0, s, 1'b0});
   endtask
   task automatic fire(input logic [24:0] b, input int k, input logic s);
      int w0 = tw;
      int n0 = tn;
      irq = b;
      for (int i = 0; i < 40 && vw !== 1'b1; i++) tick(1);
      // Drop the request while the fetch stands so it is not re-offered
      irq = b & ~(25'h1 << k);
      wait_takes(w0, n0);
      check(16'(tw_a), (s ? 16'h1c00 : 16'h0) + 16'(2 + 2 * k));
      check(16'(tn_a), (s ? 16'h0c00 : 16'h0) + 16'(1 + k));
      check(16'({tw_i, tn_i}), 16'({5'(k), 5'(k)}));
      if (irq == '0) begin
         tick(6);
         check(16'({vw, vn}), 16'h0);
      end
   endtask
   initial begin
      do_reset(1'b1, 4'h3);
      write(8'h35, 8'h02);
      check(16'(ctrl), 16'h0);
      write(8'h36, 8'h01);
      check(16'(ctrl), 16'h0);
      write(8'h35, 8'h01);
      we = 1'b0;
      check(16'(ctrl), 16'h1);
      tick(1);
      check(16'(ctrl), 16'h0);
      for (int k = 0; k < 25; k++) fire(25'h1 << k, k, 1'b0);
      fire(25'h100088, 3, 1'b0);
      fire(25'h100080, 7, 1'b0);
      fire(25'h100000, 20, 1'b0);
      set_select(1'b1);
      lat = 4'h6;
      for (int k = 0; k < 25; k++) fire(25'h1 << k, k, 1'b1);
      do_reset(1'b0, 4'h2);
      fire(25'h1, 0, 1'b0);
      set_select(1'b1);
      fire(25'h1000000, 24, 1'b1);
      give_verdict();
   end
endmodule
